// file: verilog/xor_tree_board_test.sv
// Board-level pin connectivity test: parity trees routed onto mask and host pins
`include "xor_tree_consts.svh"

// How it works
// - Each tree cascades XOR gates, one pin each
// - Tree results need no clock to evaluate
// - No results shown before reset deasserted
// - Full width drives result on A and B
// - Shared mode drives only the selected channel
// - Results 0-7 on masks, 8-11 on host
module xor_tree_board_test (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Entry control pins
    input wire logic test_mode_select_n_i,
    input wire logic power_good_in_i,
    input wire logic system_reset_in_n_i,
    input wire logic card_id_strap_bit6_i,
    input wire logic card_id_strap_bit7_i,
    input wire logic video_port_b_blank_n_i,
    input wire logic host_clock_pos_i,
    input wire logic host_clock_neg_i,
    // Graphics port generation strap level: high for the 3.0 mode
    input wire logic graphics_port_gen3_i,
    // Tester mode: full width, or shared with channel B selected when high
    input wire logic full_width_mode_i,
    input wire logic channel_b_select_i,
    // Input pins feeding each tree
    input wire logic [`TREE0_WIDTH-1:0] tree0_pins_i,
    input wire logic [`TREE1_WIDTH-1:0] tree1_pins_i,
    input wire logic [`TREE2_WIDTH-1:0] tree2_pins_i,
    input wire logic [`TREE3_WIDTH-1:0] tree3_pins_i,
    input wire logic [`TREE4_WIDTH-1:0] tree4_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree5_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree6_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree7_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree8_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree9_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree10_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree11_pins_i,
    // Normal-function drive for the shared pins
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_a_i,
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_a_oe_i,
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_b_i,
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_b_oe_i,
    input wire logic [`HOST_PIN_COUNT-1:0] func_host_a_i,
    input wire logic [`HOST_PIN_COUNT-1:0] func_host_a_oe_i,
    input wire logic [`HOST_PIN_COUNT-1:0] func_host_b_i,
    input wire logic [`HOST_PIN_COUNT-1:0] func_host_b_oe_i,
    // Channel A and B data-mask pins
    output logic [`MASK_PIN_COUNT-1:0] chan_a_mask_pin_o,
    output logic [`MASK_PIN_COUNT-1:0] chan_a_mask_pin_oe_o,
    output logic [`MASK_PIN_COUNT-1:0] chan_b_mask_pin_o,
    output logic [`MASK_PIN_COUNT-1:0] chan_b_mask_pin_oe_o,
    // Host bus pins, bit order set by the header positions
    output logic [`HOST_PIN_COUNT-1:0] host_a_pin_o,
    output logic [`HOST_PIN_COUNT-1:0] host_a_pin_oe_o,
    output logic [`HOST_PIN_COUNT-1:0] host_b_pin_o,
    output logic [`HOST_PIN_COUNT-1:0] host_b_pin_oe_o,
    // Test mode presently overriding the pins
    output logic test_active_o,
    // Clocked observation of the entry sequence
    output logic entry_order_ok_o,
    output logic entry_order_bad_o,
    output logic host_clock_seen_o,
    output logic results_deterministic_o
);

    // Raw tree results, index = result number
    wire [`RESULT_COUNT-1:0] result;

    // Trees are purely combinational so the tester needs no clock
    parity_chain #(.WIDTH(`TREE0_WIDTH)) u_tree0 (.pins_i(tree0_pins_i), .result_o(result[0]));
    parity_chain #(.WIDTH(`TREE1_WIDTH)) u_tree1 (.pins_i(tree1_pins_i), .result_o(result[1]));
    parity_chain #(.WIDTH(`TREE2_WIDTH)) u_tree2 (.pins_i(tree2_pins_i), .result_o(result[2]));
    parity_chain #(.WIDTH(`TREE3_WIDTH)) u_tree3 (.pins_i(tree3_pins_i), .result_o(result[3]));
    parity_chain #(.WIDTH(`TREE4_WIDTH)) u_tree4 (.pins_i(tree4_pins_i), .result_o(result[4]));
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree5 (
        .pins_i(tree5_pins_i),
        .result_o(result[5])
    );
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree6 (
        .pins_i(tree6_pins_i),
        .result_o(result[6])
    );
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree7 (
        .pins_i(tree7_pins_i),
        .result_o(result[7])
    );
    // Four more trees: the mapped results outnumber the stated tree count
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree8 (
        .pins_i(tree8_pins_i),
        .result_o(result[8])
    );
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree9 (
        .pins_i(tree9_pins_i),
        .result_o(result[9])
    );
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree10 (
        .pins_i(tree10_pins_i),
        .result_o(result[10])
    );
    parity_chain #(.WIDTH(`TREE_DEFAULT_WIDTH)) u_tree11 (
        .pins_i(tree11_pins_i),
        .result_o(result[11])
    );

    // Test mode level: selected, powered and out of reset. Kept unclocked
    // on purpose, since the tester may run with every clock stopped.
    wire test_active = ~test_mode_select_n_i & power_good_in_i
                       & system_reset_in_n_i;

    // Which channel may carry results in the present tester mode
    wire drive_a = test_active & (full_width_mode_i | ~channel_b_select_i);
    wire drive_b = test_active & (full_width_mode_i | channel_b_select_i);

    // Results 0 to 7 feed the mask pins of both channels
    wire [`MASK_PIN_COUNT-1:0] mask_result = result[`MASK_PIN_COUNT-1:0];

    // Results 8 to 11 feed the host pins in the header's bit order
    wire [`HOST_PIN_COUNT-1:0] host_a_result;
    wire [`HOST_PIN_COUNT-1:0] host_b_result;
    assign host_a_result[`HOST_TARGET_READY_N_BIT] = result[`HOST_RESULT_BASE];
    assign host_a_result[`HOST_RESPONSE2_N_BIT] = result[`HOST_RESULT_BASE+1];
    assign host_a_result[`HOST_RESPONSE0_N_BIT] = result[`HOST_RESULT_BASE+2];
    assign host_a_result[`HOST_BUS_REQUEST0_N_BIT] = result[`HOST_RESULT_BASE+3];
    assign host_b_result[`PRIORITY_BUS_REQUEST_N_BIT] = result[`HOST_RESULT_BASE];
    assign host_b_result[`HOST_N_A_BIT] = result[`HOST_RESULT_BASE+1];
    assign host_b_result[`HOST_RESPONSE1_N_BIT] = result[`HOST_RESULT_BASE+2];
    assign host_b_result[`PROCESSOR_RESET_N_BIT] = result[`HOST_RESULT_BASE+3];

    // In test mode the normal drive is ignored; the unselected channel
    // floats so a shared tester channel is never fought.
    assign chan_a_mask_pin_o = test_active ? mask_result : func_mask_a_i;
    assign chan_a_mask_pin_oe_o = test_active ? {`MASK_PIN_COUNT{drive_a}}
                                              : func_mask_a_oe_i;
    assign chan_b_mask_pin_o = test_active ? mask_result : func_mask_b_i;
    assign chan_b_mask_pin_oe_o = test_active ? {`MASK_PIN_COUNT{drive_b}}
                                              : func_mask_b_oe_i;
    assign host_a_pin_o = test_active ? host_a_result : func_host_a_i;
    assign host_a_pin_oe_o = test_active ? {`HOST_PIN_COUNT{drive_a}}
                                         : func_host_a_oe_i;
    assign host_b_pin_o = test_active ? host_b_result : func_host_b_i;
    assign host_b_pin_oe_o = test_active ? {`HOST_PIN_COUNT{drive_b}}
                                         : func_host_b_oe_i;
    assign test_active_o = test_active;

    // ---- Clocked observer of the entry sequence (never gates the trees) ----

    // Pin levels gathered for synchronisation. The pair counts as high only
    // in its positive phase; an xor of the legs would sit still while toggling.
    wire [`SYNC_WIDTH-1:0] pin_raw;
    assign pin_raw[`SYNC_POWER_GOOD] = power_good_in_i;
    assign pin_raw[`SYNC_RESET_N] = system_reset_in_n_i;
    assign pin_raw[`SYNC_TEST_N] = test_mode_select_n_i;
    assign pin_raw[`SYNC_STRAP6] = card_id_strap_bit6_i;
    assign pin_raw[`SYNC_STRAP7] = card_id_strap_bit7_i;
    assign pin_raw[`SYNC_HOST_CLK] = host_clock_pos_i & ~host_clock_neg_i;
    assign pin_raw[`SYNC_BLANK_N] = video_port_b_blank_n_i;

    logic [`SYNC_WIDTH-1:0] sync_meta; // First stage, read only by sync_pin
    logic [`SYNC_WIDTH-1:0] sync_pin; // Safe pin levels
    logic host_clk_prev; // Last sampled host clock level
    logic gen3_meta; // First stage of the mode strap, read only by gen3_level
    logic gen3_level; // Graphics port mode, sampled after reset
    xor_tree_pkg::entry_state_t state;
    xor_tree_pkg::entry_state_t next_state;
    logic clock_seen; // Sticky host clock toggle since arming

    // Two-flop synchroniser for every pin the observer reads except the mode strap, which has its own pair
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta <= `SYNC_RESET_VALUE;
            sync_pin <= `SYNC_RESET_VALUE;
        end else begin
            sync_meta <= pin_raw;
            sync_pin <= sync_meta;
        end
    end

    // Named synchronised levels
    wire s_pg = sync_pin[`SYNC_POWER_GOOD];
    wire s_rst_n = sync_pin[`SYNC_RESET_N];
    wire s_test_n = sync_pin[`SYNC_TEST_N];
    wire s_blank_n = sync_pin[`SYNC_BLANK_N];
    wire [1:0] s_straps = {sync_pin[`SYNC_STRAP7], sync_pin[`SYNC_STRAP6]};

    // Straps low in the 2.0 mode; in 3.0 mode straps and blank held high
    wire straps_ok = gen3_level ? ((s_straps == 2'h3) & s_blank_n)
                                : (s_straps == 2'h0);
    wire all_low = ~s_pg & ~s_rst_n & ~s_test_n;
    wire host_clk_edge = sync_pin[`SYNC_HOST_CLK] ^ host_clk_prev;

    // Mode strap passes two flops like the other pins, so it lines up with
    // the strap levels that it qualifies
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gen3_meta <= 1'b0;
            gen3_level <= 1'b0;
            host_clk_prev <= 1'b0;
        end else begin
            gen3_meta <= graphics_port_gen3_i;
            gen3_level <= gen3_meta;
            host_clk_prev <= sync_pin[`SYNC_HOST_CLK];
        end
    end

    // Entry order: all low, then power-good, then reset release
    always_comb begin
        next_state = state;
        case (state)
            xor_tree_pkg::ENTRY_IDLE: begin
                // Power-good first while reset still held
                if (all_low & straps_ok) begin
                    next_state = xor_tree_pkg::ENTRY_IDLE;
                end else if (s_pg & ~s_rst_n & ~s_test_n & straps_ok) begin
                    next_state = xor_tree_pkg::ENTRY_POWERED;
                end else if (s_rst_n & ~s_test_n) begin
                    next_state = xor_tree_pkg::ENTRY_BAD;
                end
            end
            xor_tree_pkg::ENTRY_POWERED: begin
                // Reset release arms; losing power-good or select is wrong
                if (~s_pg | s_test_n | ~straps_ok) begin
                    next_state = xor_tree_pkg::ENTRY_BAD;
                end else if (s_rst_n) begin
                    next_state = xor_tree_pkg::ENTRY_ARMED;
                end
            end
            xor_tree_pkg::ENTRY_ARMED, xor_tree_pkg::ENTRY_BAD: begin
                // Leave once the tester drops everything again or deselects test mode
                if (all_low) begin
                    next_state = xor_tree_pkg::ENTRY_IDLE;
                end else if (s_test_n) begin
                    next_state = xor_tree_pkg::ENTRY_IDLE;
                end
            end
            default: begin
                next_state = xor_tree_pkg::ENTRY_IDLE;
            end
        endcase
    end

    // State register and sticky clock-toggle flag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= xor_tree_pkg::ENTRY_IDLE;
            clock_seen <= 1'b0;
        end else begin
            state <= next_state;
            // Toggle seen while staying armed; cleared in every cycle where state or next_state is not armed
            if (next_state == xor_tree_pkg::ENTRY_ARMED
                && state == xor_tree_pkg::ENTRY_ARMED) begin
                clock_seen <= clock_seen | host_clk_edge;
            end else begin
                clock_seen <= 1'b0;
            end
        end
    end

    // Observer outputs; 3.0 mode needs no host clock for determinism
    assign entry_order_ok_o = (state == xor_tree_pkg::ENTRY_ARMED);
    assign entry_order_bad_o = (state == xor_tree_pkg::ENTRY_BAD);
    assign host_clock_seen_o = clock_seen;
    assign results_deterministic_o = entry_order_ok_o & (gen3_level | clock_seen);

endmodule : xor_tree_board_test

// file: verilog/xor_tree_consts.svh
// Constants for the board-level parity tree test block
`ifndef XOR_TREE_CONSTS_SVH
`define XOR_TREE_CONSTS_SVH

// Number of parity tree results that have a pin pair
`define RESULT_COUNT 12
// Number of data-mask pins per memory channel
`define MASK_PIN_COUNT 8
// Number of host bus pins per channel side that carry results
`define HOST_PIN_COUNT 4

// Input pin counts per tree; trees 5 to 11 have no printed count
`define TREE0_WIDTH 60
`define TREE1_WIDTH 33
`define TREE2_WIDTH 44
`define TREE3_WIDTH 41
`define TREE4_WIDTH 40
`define TREE_DEFAULT_WIDTH 32

// First result index that lands on the host bus pins
`define HOST_RESULT_BASE 8

// Bit positions in the channel A host pin vector
`define HOST_TARGET_READY_N_BIT 0
`define HOST_RESPONSE2_N_BIT 1
`define HOST_RESPONSE0_N_BIT 2
`define HOST_BUS_REQUEST0_N_BIT 3
// Bit positions in the channel B host pin vector
`define PRIORITY_BUS_REQUEST_N_BIT 0
`define HOST_N_A_BIT 1
`define HOST_RESPONSE1_N_BIT 2
`define PROCESSOR_RESET_N_BIT 3

// Bit positions in the synchronised pin vector
`define SYNC_POWER_GOOD 0
`define SYNC_RESET_N 1
`define SYNC_TEST_N 2
`define SYNC_STRAP6 3
`define SYNC_STRAP7 4
`define SYNC_HOST_CLK 5
`define SYNC_BLANK_N 6
`define SYNC_WIDTH 7

// Reset value of the synchroniser flops
`define SYNC_RESET_VALUE 7'h00

`endif

// file: verilog/xor_tree_pkg.sv
// Types shared by the parity tree test block
package xor_tree_pkg;

    // Entry sequence tracker, Gray coded along idle, powered, armed
    typedef enum logic [1:0] {
        ENTRY_IDLE = 2'h0,
        ENTRY_POWERED = 2'h1,
        ENTRY_ARMED = 2'h3,
        ENTRY_BAD = 2'h2
    } entry_state_t;

endpackage : xor_tree_pkg

// file: verilog/parity_chain.sv
// One cascade of two-input XOR gates over a set of input pins
module parity_chain #(
    parameter int WIDTH = 2
) (
    input wire logic [WIDTH-1:0] pins_i,
    output logic result_o
);

    // Running parity after each stage; stage k folds in pin k
    wire [WIDTH-1:0] stage;

    assign stage[0] = pins_i[0];

    // Each gate takes the previous stage and exactly one pin
    genvar k;
    generate
        for (k = 1; k < WIDTH; k = k + 1) begin : g_stage
            assign stage[k] = stage[k-1] ^ pins_i[k];
        end
    endgenerate

    assign result_o = stage[WIDTH-1];

endmodule : parity_chain

// file: tb/xor_tree_board_test_sva.sv
// Checker for the parity tree test block pins and entry observer
`include "xor_tree_consts.svh"
module xor_tree_board_test_chk (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic test_mode_select_n_i,
    input wire logic power_good_in_i,
    input wire logic system_reset_in_n_i,
    input wire logic full_width_mode_i,
    input wire logic channel_b_select_i,
    input wire logic [`TREE0_WIDTH-1:0] tree0_pins_i,
    input wire logic [`TREE_DEFAULT_WIDTH-1:0] tree8_pins_i,
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_a_i,
    input wire logic [`MASK_PIN_COUNT-1:0] func_mask_a_oe_i,
    input wire logic [`MASK_PIN_COUNT-1:0] chan_a_mask_pin_o,
    input wire logic [`MASK_PIN_COUNT-1:0] chan_a_mask_pin_oe_o,
    input wire logic [`MASK_PIN_COUNT-1:0] chan_b_mask_pin_o,
    input wire logic [`MASK_PIN_COUNT-1:0] chan_b_mask_pin_oe_o,
    input wire logic [`HOST_PIN_COUNT-1:0] host_a_pin_o,
    input wire logic test_active_o,
    input wire logic entry_order_ok_o,
    input wire logic entry_order_bad_o,
    input wire logic results_deterministic_o
);
    // One clock domain, so clock and disable are given once
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Test mode split by tester mode
    wire logic full_on = test_active_o && full_width_mode_i;
    wire logic shr_on = test_active_o && !full_width_mode_i;
    active_eq_a: assert property (test_active_o == (!test_mode_select_n_i
        && power_good_in_i && system_reset_in_n_i)) else $error("test mode level wrong");
    full_both_a: assert property (full_on |-> chan_a_mask_pin_oe_o == 8'hFF
        && chan_b_mask_pin_oe_o == 8'hFF && chan_a_mask_pin_o == chan_b_mask_pin_o)
        else $error("full width pins differ");
    shared_a_a: assert property (shr_on && !channel_b_select_i |->
        chan_a_mask_pin_oe_o == 8'hFF && chan_b_mask_pin_oe_o == 8'h00)
        else $error("channel A mode enables wrong");
    shared_b_a: assert property (shr_on && channel_b_select_i |->
        chan_b_mask_pin_oe_o == 8'hFF && chan_a_mask_pin_oe_o == 8'h00)
        else $error("channel B mode enables wrong");
    normal_pins_a: assert property (!test_active_o |-> chan_a_mask_pin_o == func_mask_a_i
        && chan_a_mask_pin_oe_o == func_mask_a_oe_i) else $error("normal drive lost");
    tree_parity_a: assert property (full_on |-> chan_a_mask_pin_o[0] == ^tree0_pins_i)
        else $error("tree 0 parity wrong");
    host_parity_a: assert property (full_on |-> host_a_pin_o[0] == ^tree8_pins_i)
        else $error("tree 8 parity wrong");
    entry_order_a: assert property ($rose(entry_order_ok_o) |->
        $past(system_reset_in_n_i, 3) && $past(power_good_in_i, 4))
        else $error("armed without ordered entry");
    determ_ok_a: assert property (results_deterministic_o |->
        $past(system_reset_in_n_i, 3) && $past(power_good_in_i, 3))
        else $error("results flagged before entry");
endmodule : xor_tree_board_test_chk

bind xor_tree_board_test xor_tree_board_test_chk chk (.ref_clk_i, .rst_i,
    .test_mode_select_n_i, .power_good_in_i, .system_reset_in_n_i, .full_width_mode_i,
    .channel_b_select_i, .tree0_pins_i, .tree8_pins_i, .func_mask_a_i, .func_mask_a_oe_i,
    .chan_a_mask_pin_o, .chan_a_mask_pin_oe_o, .chan_b_mask_pin_o, .chan_b_mask_pin_oe_o,
    .host_a_pin_o, .test_active_o, .entry_order_ok_o, .entry_order_bad_o,
    .results_deterministic_o);

// file: tb/ate_model.sv
// Tester side model: strap levels per port mode and the host clock pair
module ate_model (
    input wire logic ref_clk_i,
    input wire logic gen3_i,
    input wire logic run_clk_i,
    output logic strap6_o,
    output logic strap7_o,
    output logic blank_n_o,
    output logic clk_pos_o,
    output logic clk_neg_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Straps low for 2.0 entry, high with blank for 3.0
    assign strap6_o = gen3_i;
    assign strap7_o = gen3_i;
    assign blank_n_o = 1'b1;
    // Pair runs only when asked, so stands still like a gated source
    initial clk_pos_o = 1'b0;
    always @(negedge ref_clk_i) if (run_clk_i) clk_pos_o <= ~clk_pos_o;
    assign clk_neg_o = ~clk_pos_o;
endmodule : ate_model

// file: tb/xor_tree_board_test_tb.sv
// Self-checking bench for the parity tree test block
`include "xor_tree_consts.svh"
module xor_tree_board_test_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Pins driven by the bench or the tester model
    logic ref_clk_i, rst_i, test_mode_select_n_i, power_good_in_i, system_reset_in_n_i;
    logic card_id_strap_bit6_i, card_id_strap_bit7_i, video_port_b_blank_n_i;
    logic host_clock_pos_i, host_clock_neg_i, graphics_port_gen3_i, run_clk;
    logic full_width_mode_i, channel_b_select_i;
    logic [`TREE0_WIDTH-1:0] tree0_pins_i;
    logic [`TREE1_WIDTH-1:0] tree1_pins_i;
    logic [`TREE2_WIDTH-1:0] tree2_pins_i;
    logic [`TREE3_WIDTH-1:0] tree3_pins_i;
    logic [`TREE4_WIDTH-1:0] tree4_pins_i;
    logic [`TREE_DEFAULT_WIDTH-1:0] tdef [5:11]; // Trees 5 to 11
    logic [7:0] func_mask_a_i, func_mask_a_oe_i, func_mask_b_i, func_mask_b_oe_i;
    logic [3:0] func_host_a_i, func_host_a_oe_i, func_host_b_i, func_host_b_oe_i;
    // Observed outputs
    logic [7:0] chan_a_mask_pin_o, chan_a_mask_pin_oe_o, chan_b_mask_pin_o, chan_b_mask_pin_oe_o;
    logic [3:0] host_a_pin_o, host_a_pin_oe_o, host_b_pin_o, host_b_pin_oe_o;
    logic test_active_o, entry_order_ok_o, entry_order_bad_o;
    logic host_clock_seen_o, results_deterministic_o;
    int n_mismatch = 0;
    int compares = 0;

    xor_tree_board_test dut (.ref_clk_i, .rst_i, .test_mode_select_n_i, .power_good_in_i,
        .system_reset_in_n_i, .card_id_strap_bit6_i, .card_id_strap_bit7_i,
        .video_port_b_blank_n_i, .host_clock_pos_i, .host_clock_neg_i, .graphics_port_gen3_i,
        .full_width_mode_i, .channel_b_select_i, .tree0_pins_i, .tree1_pins_i, .tree2_pins_i,
        .tree3_pins_i, .tree4_pins_i, .tree5_pins_i(tdef[5]), .tree6_pins_i(tdef[6]),
        .tree7_pins_i(tdef[7]), .tree8_pins_i(tdef[8]), .tree9_pins_i(tdef[9]),
        .tree10_pins_i(tdef[10]), .tree11_pins_i(tdef[11]), .func_mask_a_i,
        .func_mask_a_oe_i, .func_mask_b_i, .func_mask_b_oe_i, .func_host_a_i,
        .func_host_a_oe_i, .func_host_b_i, .func_host_b_oe_i, .chan_a_mask_pin_o,
        .chan_a_mask_pin_oe_o, .chan_b_mask_pin_o, .chan_b_mask_pin_oe_o, .host_a_pin_o,
        .host_a_pin_oe_o, .host_b_pin_o, .host_b_pin_oe_o, .test_active_o, .entry_order_ok_o,
        .entry_order_bad_o, .host_clock_seen_o, .results_deterministic_o);
    ate_model ate (.ref_clk_i, .gen3_i(graphics_port_gen3_i), .run_clk_i(run_clk),
        .strap6_o(card_id_strap_bit6_i), .strap7_o(card_id_strap_bit7_i),
        .blank_n_o(video_port_b_blank_n_i), .clk_pos_o(host_clock_pos_i),
        .clk_neg_o(host_clock_neg_i));

    // 25 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : step

    // Drive one tree group; idle trees held at zero so they stay unexercised
    task automatic set_trees(input logic [11:0] p, input logic [11:0] q);
        tree0_pins_i = {q[0], {(`TREE0_WIDTH-2){1'b0}}, p[0]};
        tree1_pins_i = {q[1], {(`TREE1_WIDTH-2){1'b0}}, p[1]};
        tree2_pins_i = {q[2], {(`TREE2_WIDTH-2){1'b0}}, p[2]};
        tree3_pins_i = {q[3], {(`TREE3_WIDTH-2){1'b0}}, p[3]};
        tree4_pins_i = {q[4], {(`TREE4_WIDTH-2){1'b0}}, p[4]};
        for (int k = 5; k < 12; k++) tdef[k] = {q[k], {(`TREE_DEFAULT_WIDTH-2){1'b0}}, p[k]};
    endtask : set_trees

    // Restart the observer, then lower all, raise power-good, then reset
    task automatic enter(input logic gen3);
        rst_i = 1'b1;
        graphics_port_gen3_i = gen3;
        {test_mode_select_n_i, power_good_in_i, system_reset_in_n_i} = 3'h0;
        step(1);
        rst_i = 1'b0;
        step(4);
        power_good_in_i = 1'b1;
        step(4);
        chk(16'(test_active_o), 16'h0000);
        chk(16'(entry_order_ok_o), 16'h0000);
        system_reset_in_n_i = 1'b1;
        step(4);
        chk(16'(entry_order_ok_o), 16'h0001);
        chk(16'(test_active_o), 16'h0001);
    endtask : enter

    // Outside test mode the normal drive owns the pins
    task automatic t_normal();
        {func_mask_a_i, func_mask_a_oe_i, func_host_a_i, func_host_a_oe_i} = 24'hA55A96;
        {func_mask_b_i, func_mask_b_oe_i, func_host_b_i, func_host_b_oe_i} = 24'hC33C69;
        test_mode_select_n_i = 1'b1;
        step(1);
        chk({chan_a_mask_pin_o, chan_a_mask_pin_oe_o}, 16'hA55A);
        chk({chan_b_mask_pin_o, chan_b_mask_pin_oe_o}, 16'hC33C);
        chk({host_a_pin_o, host_a_pin_oe_o, host_b_pin_o, host_b_pin_oe_o}, 16'h9669);
        $display("test normal pins done");
    endtask : t_normal

    // 2.0 entry: results flagged only once the host pair has toggled
    task automatic t_gen2();
        enter(1'b0);
        chk(16'(results_deterministic_o), 16'h0000);
        run_clk = 1'b1;
        step(8);
        chk(16'({host_clock_seen_o, results_deterministic_o}), 16'h0003);
        run_clk = 1'b0;
        $display("test 2.0 entry done");
    endtask : t_gen2

    // 3.0 entry with straps and blank high needs no host clock
    task automatic t_gen3();
        enter(1'b1);
        chk(16'(results_deterministic_o), 16'h0001);
        $display("test 3.0 entry done");
    endtask : t_gen3

    // Reset released ahead of power-good is caught
    task automatic t_bad_order();
        enter(1'b0);
        power_good_in_i = 1'b0;
        system_reset_in_n_i = 1'b0;
        rst_i = 1'b1;
        step(1);
        rst_i = 1'b0;
        system_reset_in_n_i = 1'b1;
        step(4);
        power_good_in_i = 1'b1;
        step(5);
        chk(16'({entry_order_ok_o, entry_order_bad_o}), 16'h0001);
        $display("test bad order done");
    endtask : t_bad_order

    // Full width and shared results over allowed tree groups, no clock edge
    task automatic t_results();
        logic [11:0] grp [3];
        logic [11:0] e;
        grp = '{12'hFE9, 12'h006, 12'h010};
        enter(1'b0);
        for (int g = 0; g < 3; g++) begin
            for (int s = 0; s < 3; s++) begin
                full_width_mode_i = (s == 0);
                channel_b_select_i = (s == 2);
                set_trees(12'hA5C & grp[g], 12'h3C6 & grp[g]);
                e = (12'hA5C ^ 12'h3C6) & grp[g];
                #1;
                if (s != 2) chk({chan_a_mask_pin_o, chan_a_mask_pin_oe_o},
                    {e[7:0], 8'hFF});
                if (s != 1) chk({chan_b_mask_pin_o, chan_b_mask_pin_oe_o},
                    {e[7:0], 8'hFF});
                if (s == 1) chk(16'(chan_b_mask_pin_oe_o), 16'h0000);
                if (s == 2) chk(16'(chan_a_mask_pin_oe_o), 16'h0000);
                if (s == 0) chk({host_a_pin_o, host_b_pin_o,
                    host_a_pin_oe_o, host_b_pin_oe_o}, {e[11:8], e[11:8], 8'hFF});
                // Hold each setting for a cycle so the checker sees it
                step(1);
            end
        end
        set_trees(12'h000, 12'h000);
        $display("test results done");
    endtask : t_results

    task automatic stop_test();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Watchdog far beyond the 85 cycles the tests take
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        n_mismatch++;
        stop_test();
    end

    // Main sequence, reset held for four cycles
    initial begin
        rst_i = 1'b1;
        {test_mode_select_n_i, power_good_in_i, system_reset_in_n_i} = 3'h0;
        {graphics_port_gen3_i, run_clk, full_width_mode_i, channel_b_select_i} = 4'h0;
        {func_mask_a_i, func_mask_a_oe_i, func_mask_b_i, func_mask_b_oe_i} = 32'h0;
        {func_host_a_i, func_host_a_oe_i, func_host_b_i, func_host_b_oe_i} = 16'h0;
        set_trees(12'h000, 12'h000);
        step(4);
        rst_i = 1'b0;
        t_normal();
        t_gen2();
        t_results();
        t_gen3();
        t_bad_order();
        t_normal();
        stop_test();
    end
endmodule : xor_tree_board_test_tb
